//--- tb/clock_tree_and_wait_mode_control_bench.sv
// self-checking bench for the clock tree and wait mode control
module clock_tree_and_wait_mode_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // design inputs
  logic       clock = 1'h0, sys_rst = 1'h1;
  logic       xin_tick = 1'h0, hs_osc_tick = 1'h0, ls_osc_tick = 1'h0, wdt_osc_tick = 1'h0;
  logic       sysclk_osc_sel = 1'h0, xin_pin_func = 1'h0, xin_stop = 1'h0;
  logic       osc_select = 1'h0, hs_osc_on = 1'h0, ls_osc_stop = 1'h0;
  logic [2:0] hs_osc_div = 3'h0;
  logic       div128_src_sel = 1'h0, wdt_src_protect = 1'h0;
  logic [1:0] cpu_div_sel = 2'h0, wake_div_sel = 2'h0;
  logic       cpu_div8_sel = 1'h0, div_sel_wr = 1'h0, wake_div_ctrl = 1'h0;
  logic       periph_clk_wait_stop = 1'h0, osc_stop_irq_en = 1'h0, wait_entry = 1'h0;
  logic       halt_instruction = 1'h0, periph_irq = 1'h0;
  // design outputs
  logic       cpu_clk_en, onchip_periph_clk, hs_osc_full_clk, hs_osc_div_clk;
  logic       ls_osc_clk, div128_clk, wdt_osc_clk, wait_active;
  logic       cpu_div8_sel_q, xin_mode_active;
  logic [4:0] periph_clk_en;
  logic [1:0] cpu_div_sel_q;
  // tick lines by index: 0 wdt 1 div128 2 ls 3 hsdiv 4 hsfull 5 onchip 6..10 periph 11 cpu
  wire  [11:0] tk = {cpu_clk_en, periph_clk_en, onchip_periph_clk, hs_osc_full_clk,
                     hs_osc_div_clk, ls_osc_clk, div128_clk, wdt_osc_clk};
  int         pdiv[5] = '{1, 2, 4, 8, 32};
  int         cdiv[5] = '{1, 2, 4, 16, 8};
  int         miscompares = 0, checks_done = 0, osc_n = 0;
  clock_tree_and_wait_mode_control dut (
    .clock, .sys_rst, .xin_tick, .hs_osc_tick, .ls_osc_tick, .wdt_osc_tick,
    .sysclk_osc_sel, .xin_pin_func, .xin_stop, .osc_select, .hs_osc_on, .ls_osc_stop,
    .hs_osc_div, .div128_src_sel, .wdt_src_protect, .cpu_div_sel, .cpu_div8_sel,
    .div_sel_wr, .wake_div_ctrl, .wake_div_sel, .periph_clk_wait_stop,
    .osc_stop_irq_en, .wait_entry, .halt_instruction, .periph_irq, .cpu_clk_en,
    .periph_clk_en, .onchip_periph_clk, .hs_osc_full_clk, .hs_osc_div_clk, .ls_osc_clk,
    .div128_clk, .wdt_osc_clk, .wait_active, .cpu_div_sel_q, .cpu_div8_sel_q,
    .xin_mode_active);
  // 100 MHz system clock
  always #5 clock = ~clock;
  // oscillator square waves: periods 2, 2, 4 and 6 clocks
  always @(posedge clock)
  begin
    osc_n <= osc_n + 1;
    xin_tick <= ~xin_tick;
    hs_osc_tick <= ~hs_osc_tick;
    if (osc_n % 2 == 0)
      ls_osc_tick <= ~ls_osc_tick;
    if (osc_n % 3 == 0)
      wdt_osc_tick <= ~wdt_osc_tick;
  end
  // count and report one comparison
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // second gap between pulses of tick line i, in clocks
  task automatic per(input int i, input int exp);
    int n;
    int g;
    n = 0;
    g = 0;
    repeat (3)
    begin
      g = 0;
      @(negedge clock);
      while (tk[i] !== 1'h1 && n < 8000)
      begin
        @(negedge clock);
        g++;
        n++;
      end
    end
    cmp(32'(g + 1), 32'(exp));
  endtask
  // tick line i stays low once the pipeline has drained
  task automatic quiet(input int i, input int n);
    logic seen;
    seen = 1'h0;
    repeat (8) @(negedge clock);
    repeat (n)
    begin
      @(negedge clock);
      if (tk[i] !== 1'h0)
        seen = 1'h1;
    end
    cmp(32'(seen), 32'h0);
  endtask
  // low current read unused
  // write the cpu divider selects with a one-cycle strobe
  task automatic wr_div(input logic [1:0] s, input logic d8);
    @(posedge clock);
    cpu_div_sel <= s;
    cpu_div8_sel <= d8;
    div_sel_wr <= 1'h1;
    @(posedge clock);
    div_sel_wr <= 1'h0;
  endtask
  // interrupt flag outside block
  // request wait by strobe or halt, flag rises two edges on
  task automatic enter(input logic by_halt);
    @(posedge clock);
    wait_entry <= ~by_halt;
    halt_instruction <= by_halt;
    @(posedge clock);
    wait_entry <= 1'h0;
    halt_instruction <= 1'h0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    cmp(32'(wait_active), 32'h1);
  endtask
  // wake by peripheral interrupt, flag falls two edges on
  task automatic leave();
    @(posedge clock);
    periph_irq <= 1'h1;
    @(posedge clock);
    periph_irq <= 1'h0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    cmp(32'(wait_active), 32'h0);
  endtask
  // verdict and end of run
  task automatic tally_and_finish();
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // cut a hang short
  initial
  begin
    #200us;
    miscompares++;
    tally_and_finish();
  end
  // test sequence
  initial
  begin
    repeat (20) @(negedge clock);
    cmp(32'({cpu_div8_sel_q, cpu_div_sel_q, wait_active}), 32'h0);
    @(posedge clock);
    sys_rst <= 1'h0;
    xin_pin_func <= 1'h1;
    wdt_src_protect <= 1'h1;
    repeat (8) @(negedge clock);
    cmp(32'(xin_mode_active), 32'h1);
    for (int k = 0; k < 5; k++)
      per(6 + k, 2 * pdiv[k]);
    for (int j = 0; j < 5; j++)
    begin
      wr_div(2'(j), j == 4);
      per(11, 2 * cdiv[j]);
    end
    wr_div(2'h0, 1'h0);
    per(5, 4);
    per(2, 4);
    per(0, 6);
    per(1, 512);
    quiet(4, 100);
    @(posedge clock);
    ls_osc_stop <= 1'h1;
    quiet(2, 100);
    @(posedge clock);
    ls_osc_stop <= 1'h0;
    periph_clk_wait_stop <= 1'h1;
    wake_div_sel <= 2'h2;
    enter(1'h0);
    quiet(6, 100);
    quiet(11, 100);
    per(2, 4);
    per(0, 6);
    leave();
    cmp(32'(cpu_div_sel_q), 32'h2);
    cmp(32'(cpu_div8_sel_q), 32'h0);
    per(11, 8);
    @(posedge clock);
    hs_osc_on <= 1'h1;
    per(4, 2);
    @(posedge clock);
    sysclk_osc_sel <= 1'h1;
    osc_select <= 1'h1;
    periph_clk_wait_stop <= 1'h0;
    wr_div(2'h0, 1'h0);
    per(5, 4);
    per(3, 4);
    per(4, 2);
    per(11, 4);
    @(posedge clock);
    hs_osc_div <= 3'h7;
    per(3, 18);
    per(11, 18);
    @(posedge clock);
    hs_osc_div <= 3'h1;
    div128_src_sel <= 1'h1;
    per(1, 768);
    enter(1'h1);
    quiet(11, 100);
    per(6, 6);
    per(4, 2);
    per(3, 6);
    per(5, 6);
    leave();
    @(posedge clock);
    osc_stop_irq_en <= 1'h0;
    osc_select <= 1'h0;
    wr_div(2'h0, 1'h0);
    per(5, 4);
    per(11, 4);
    @(posedge clock);
    sysclk_osc_sel <= 1'h0;
    osc_stop_irq_en <= 1'h1;
    wake_div_ctrl <= 1'h1;
    enter(1'h0);
    per(11, 2);
    leave();
    cmp(32'(cpu_div8_sel_q), 32'h1);
    per(11, 16);
    enter(1'h0);
    // reset in mid-run leaves wait and restores the divider
    @(posedge clock);
    sys_rst <= 1'h1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'h0;
    @(negedge clock);
    cmp(32'({cpu_div8_sel_q, cpu_div_sel_q, wait_active}), 32'h0);
    tally_and_finish();
  end
endmodule

//--- tb/clock_tree_monitor.sv
// concurrent checks on the clock tree and wait mode ports
module clock_tree_monitor (
  // clock and reset
  input wire logic       clock,
  input wire logic       sys_rst,
  // controls
  input wire logic       hs_osc_on,
  input wire logic       ls_osc_stop,
  input wire logic [1:0] cpu_div_sel,
  input wire logic       cpu_div8_sel,
  input wire logic       div_sel_wr,
  input wire logic [1:0] wake_div_sel,
  input wire logic       wake_div_ctrl,
  input wire logic       periph_clk_wait_stop,
  input wire logic       osc_stop_irq_en,
  input wire logic       wait_entry,
  input wire logic       halt_instruction,
  input wire logic       periph_irq,
  // generated ticks and status
  input wire logic       cpu_clk_en,
  input wire logic [4:0] periph_clk_en,
  input wire logic       hs_osc_full_clk,
  input wire logic       ls_osc_clk,
  input wire logic       div128_clk,
  input wire logic       wait_active,
  input wire logic [1:0] cpu_div_sel_q,
  input wire logic       cpu_div8_sel_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // one domain: shared clock and reset
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wait_entry_a: assert property (
    ((wait_entry || halt_instruction) && !wait_active && !periph_irq) ##1 !periph_irq
      |=> wait_active)
    else $error("wait flag late after entry");
  wait_exit_a: assert property (
    wait_active && periph_irq |=> ##1 !wait_active)
    else $error("wait flag late after wake");
  cpu_gated_a: assert property (
    wait_active && $past(wait_active) && !osc_stop_irq_en && !$past(osc_stop_irq_en, 3)
      |-> !cpu_clk_en)
    else $error("cpu tick during wait");
  periph_gated_a: assert property (
    wait_active && $past(wait_active) && periph_clk_wait_stop
      && $past(periph_clk_wait_stop, 3) |-> periph_clk_en == 5'h00)
    else $error("peripheral tick during wait");
  hs_off_a: assert property (
    (!hs_osc_on) [*6] |-> !hs_osc_full_clk)
    else $error("fast tick with oscillator off");
  ls_off_a: assert property (
    ls_osc_stop [*6] |-> !ls_osc_clk)
    else $error("slow tick with oscillator off");
  div_write_a: assert property (
    div_sel_wr && !wait_active && !periph_irq
      |=> cpu_div_sel_q == $past(cpu_div_sel) && cpu_div8_sel_q == $past(cpu_div8_sel))
    else $error("divider select not written");
  wake_load_a: assert property (
    wait_active && periph_irq
      |=> cpu_div_sel_q == $past(wake_div_sel) && cpu_div8_sel_q == $past(wake_div_ctrl))
    else $error("wake divider not loaded");
  periph_nest_a: assert property (
    |periph_clk_en[4:1] |-> periph_clk_en[0])
    else $error("divided tick off boundary");
  // main scenarios reached
  cover property (wait_active && periph_irq);
  cover property (div128_clk);
  cover property (hs_osc_full_clk && wait_active);
  cover property (cpu_clk_en && wait_active);
endmodule
bind clock_tree_and_wait_mode_control clock_tree_monitor chk (
  .clock, .sys_rst, .hs_osc_on, .ls_osc_stop, .cpu_div_sel, .cpu_div8_sel,
  .div_sel_wr, .wake_div_sel, .wake_div_ctrl, .periph_clk_wait_stop, .osc_stop_irq_en,
  .wait_entry, .halt_instruction, .periph_irq, .cpu_clk_en, .periph_clk_en,
  .hs_osc_full_clk, .ls_osc_clk, .div128_clk, .wait_active, .cpu_div_sel_q,
  .cpu_div8_sel_q);

//--- verilog/clk_ctrl_consts.svh
// constants for the clock tree and wait mode control block
`ifndef CLK_CTRL_CONSTS_SVH
`define CLK_CTRL_CONSTS_SVH
`define PDIV_W        5
`define PDIV_F2_BIT   0
`define PDIV_F4_BIT   1
`define PDIV_F8_BIT   2
`define PDIV_F32_BIT  4
`define CDIV_W        4
`define CDIV_1        4'h0
`define CDIV_2        4'h1
`define CDIV_4        4'h3
`define CDIV_8        4'h7
`define CDIV_16       4'hF
`define SEL_D1        2'h0
`define SEL_D2        2'h1
`define SEL_D4        2'h2
`define SEL_D16       2'h3
`define HSDIV_W       3
`define HSDIV_MIN     4'h2
`define D128_HALF     6'h3F
`define WAKE_CTRL_RST 1'h0
`define WAKE_SEL_RST  2'h0
`endif

//--- verilog/clk_ctrl_pkg.sv
// shared types for the clock tree and wait mode control block
package clk_ctrl_pkg;
  typedef enum logic [1:0] {
    run_st  = 2'b00,
    wait_st = 2'b01
  } power_state_type;
endpackage

//--- verilog/clk_div_n.sv
// enabled divider making a one-cycle tick every ratio cycles of its source tick
module clk_div_n (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // source tick and ratio minus one
  input  wire logic       src_tick,
  input  wire logic [5:0] ratio_m1,
  // divided tick
  output logic            out_tick
);
  logic [5:0] cnt_q;
  // count source ticks, ratio compared on every source tick so a change can cut the current period short
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q    <= 6'h00;
      out_tick <= 1'b0;
    end
    else
    begin
      out_tick <= 1'b0;
      if (src_tick)
      begin
        if (cnt_q >= ratio_m1)
        begin
          cnt_q    <= 6'h00;
          out_tick <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 6'h01;
      end
    end
  end
endmodule

//--- verilog/clock_tree_and_wait_mode_control.sv
// clock tree, cpu divider and wait mode control
`include "clk_ctrl_consts.svh"
module clock_tree_and_wait_mode_control (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // oscillator source levels from pins, made one clock wide by edge detection after sync
  input  wire logic       xin_tick,
  input  wire logic       hs_osc_tick,
  input  wire logic       ls_osc_tick,
  input  wire logic       wdt_osc_tick,
  // source control bits
  input  wire logic       sysclk_osc_sel,
  input  wire logic       xin_pin_func,
  input  wire logic       xin_stop,
  input  wire logic       osc_select,
  input  wire logic       hs_osc_on,
  input  wire logic       ls_osc_stop,
  input  wire logic [2:0] hs_osc_div,
  input  wire logic       div128_src_sel,
  input  wire logic       wdt_src_protect,
  // cpu divider control
  input  wire logic [1:0] cpu_div_sel,
  input  wire logic       cpu_div8_sel,
  input  wire logic       div_sel_wr,
  input  wire logic       wake_div_ctrl,
  input  wire logic [1:0] wake_div_sel,
  // wait mode control
  input  wire logic       periph_clk_wait_stop,
  input  wire logic       osc_stop_irq_en,
  input  wire logic       wait_entry,
  input  wire logic       halt_instruction,
  input  wire logic       periph_irq,
  // generated clock ticks
  output logic            cpu_clk_en,
  output logic [4:0]      periph_clk_en,
  output logic            onchip_periph_clk,
  output logic            hs_osc_full_clk,
  output logic            hs_osc_div_clk,
  output logic            ls_osc_clk,
  output logic            div128_clk,
  output logic            wdt_osc_clk,
  // status
  output logic            wait_active,
  output logic [1:0]      cpu_div_sel_q,
  output logic            cpu_div8_sel_q,
  output logic            xin_mode_active
);
  // synchronised oscillator edges
  logic xin_s, hs_s, ls_s, wdt_s;
  logic xin_p_q, hs_p_q, ls_p_q, wdt_p_q;
  logic xin_t, hs_t, ls_t, wdt_t;
  sync2 u_sync_xin (
    .clock  (clock),
    .sys_rst(sys_rst),
    .din    (xin_tick),
    .dout   (xin_s)
  );
  sync2 u_sync_hs (
    .clock  (clock),
    .sys_rst(sys_rst),
    .din    (hs_osc_tick),
    .dout   (hs_s)
  );
  sync2 u_sync_ls (
    .clock  (clock),
    .sys_rst(sys_rst),
    .din    (ls_osc_tick),
    .dout   (ls_s)
  );
  sync2 u_sync_wdt (
    .clock  (clock),
    .sys_rst(sys_rst),
    .din    (wdt_osc_tick),
    .dout   (wdt_s)
  );

  // rising edge detection on synchronised levels
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      xin_p_q <= 1'b0;
      hs_p_q  <= 1'b0;
      ls_p_q  <= 1'b0;
      wdt_p_q <= 1'b0;
    end
    else
    begin
      xin_p_q <= xin_s;
      hs_p_q  <= hs_s;
      ls_p_q  <= ls_s;
      wdt_p_q <= wdt_s;
    end
  end
  assign xin_t = xin_s & ~xin_p_q;
  assign hs_t  = hs_s & ~hs_p_q & hs_osc_on;
  assign ls_t  = ls_s & ~ls_p_q & ~ls_osc_stop;
  assign wdt_t = wdt_s & ~wdt_p_q;

  // high-speed divided clock, ratio 2..9
  logic       hs_div_t;
  logic [5:0] hs_ratio_m1;
  assign hs_ratio_m1 = {2'h0, 4'({1'b0, hs_osc_div} + `HSDIV_MIN - 4'h1)};
  clk_div_n u_hs_div (
    .clock   (clock),
    .sys_rst (sys_rst),
    .src_tick(hs_t),
    .ratio_m1(hs_ratio_m1),
    .out_tick(hs_div_t)
  );

  // divide by 128 from low-speed or divided high-speed source
  logic       d128_src;
  logic       d128_t;
  assign d128_src = div128_src_sel ? hs_div_t : ls_t;

  // halve the source first: the 6-bit divider alone reaches only 64
  logic       d128_half_q;
  logic       d128_pre;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      d128_half_q <= 1'b0;
    else if (d128_src)
      d128_half_q <= ~d128_half_q;
  end
  assign d128_pre = d128_src & d128_half_q;
  clk_div_n u_d128 (
    .clock   (clock),
    .sys_rst (sys_rst),
    .src_tick(d128_pre),
    .ratio_m1(`D128_HALF),
    .out_tick(d128_t)
  );

  // system source select
  logic xin_mode, hs_mode, sys_t, onchip_t;
  assign xin_mode = ~sysclk_osc_sel & xin_pin_func & ~xin_stop;
  assign hs_mode  = sysclk_osc_sel & hs_osc_on & osc_select;
  assign onchip_t = osc_select ? hs_div_t : ls_t;
  always_comb
  begin
    if (xin_mode)
      sys_t = xin_t;
    else if (hs_mode)
      sys_t = hs_div_t;
    else if (sysclk_osc_sel && !osc_select)
      sys_t = ls_t;
    else
      sys_t = 1'b0;
  end

  // wait state machine
  clk_ctrl_pkg::power_state_type state_q, state_d;
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      clk_ctrl_pkg::run_st:
        if (wait_entry || halt_instruction)
          state_d = clk_ctrl_pkg::wait_st;
      clk_ctrl_pkg::wait_st:
        if (periph_irq)
          state_d = clk_ctrl_pkg::run_st;
      default:
        state_d = clk_ctrl_pkg::run_st;
    endcase
  end
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      state_q <= clk_ctrl_pkg::run_st;
    else
      state_q <= state_d;
  end

  // cpu clock kept in wait if oscillation stop interrupt was enabled at entry
  logic keep_cpu_q;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      keep_cpu_q <= 1'b0;
    else if (state_q == clk_ctrl_pkg::run_st && state_d == clk_ctrl_pkg::wait_st)
      keep_cpu_q <= osc_stop_irq_en;
  end

  // divider select bits, software written or taken from wake settings
  logic wake_load;
  assign wake_load = (state_q == clk_ctrl_pkg::wait_st) && periph_irq;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cpu_div_sel_q  <= `SEL_D1;
      cpu_div8_sel_q <= 1'b0;
    end
    else if (wake_load)
    begin
      cpu_div_sel_q  <= wake_div_sel;
      cpu_div8_sel_q <= wake_div_ctrl;
    end
    else if (div_sel_wr)
    begin
      cpu_div_sel_q  <= cpu_div_sel;
      cpu_div8_sel_q <= cpu_div8_sel;
    end
  end

  // cpu divide ratio minus one
  logic [`CDIV_W-1:0] cdiv_m1;
  always_comb
  begin
    if (cpu_div8_sel_q)
      cdiv_m1 = `CDIV_8;
    else if (cpu_div_sel_q == `SEL_D1)
      cdiv_m1 = `CDIV_1;
    else if (cpu_div_sel_q == `SEL_D2)
      cdiv_m1 = `CDIV_2;
    else if (cpu_div_sel_q == `SEL_D4)
      cdiv_m1 = `CDIV_4;
    else
      cdiv_m1 = `CDIV_16;
  end

  // cpu divider; ratio compared on every source tick, not held until wrap
  logic [`CDIV_W-1:0] ccnt_q;
  logic               cpu_t;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      ccnt_q <= 4'h0;
    else if (sys_t)
      ccnt_q <= (ccnt_q >= cdiv_m1) ? 4'h0 : ccnt_q + 4'h1;
  end
  assign cpu_t = sys_t && (ccnt_q >= cdiv_m1);

  // peripheral dividers 2, 4, 8, 32 from a free counter
  logic [`PDIV_W-1:0] pcnt_q;
  logic [`PDIV_W-1:0] pdiv_t;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      pcnt_q <= 5'h00;
    else if (sys_t)
      pcnt_q <= pcnt_q + 5'h01;
  end
  assign pdiv_t[0] = sys_t;
  assign pdiv_t[1] = sys_t & (&pcnt_q[`PDIV_F2_BIT:0]);
  assign pdiv_t[2] = sys_t & (&pcnt_q[`PDIV_F4_BIT:0]);
  assign pdiv_t[3] = sys_t & (&pcnt_q[`PDIV_F8_BIT:0]);
  assign pdiv_t[4] = sys_t & (&pcnt_q[`PDIV_F32_BIT:0]);

  // gating terms
  logic in_wait, periph_gate, cpu_gate;
  assign in_wait     = (state_q == clk_ctrl_pkg::wait_st);
  assign periph_gate = in_wait & periph_clk_wait_stop;
  assign cpu_gate    = in_wait & ~keep_cpu_q;

  // registered outputs, whole ticks only so no runt appears
  // glitch free gating
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cpu_clk_en    <= 1'b0;
      periph_clk_en <= 5'h00;
    end
    else
    begin
      cpu_clk_en    <= cpu_t & ~cpu_gate;
      periph_clk_en <= pdiv_t & {`PDIV_W{~periph_gate}};
    end
  end

  // oscillator derived outputs, never gated by wait
  // runs in wait
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      onchip_periph_clk <= 1'b0;
      hs_osc_full_clk   <= 1'b0;
      hs_osc_div_clk    <= 1'b0;
      ls_osc_clk        <= 1'b0;
      div128_clk        <= 1'b0;
      wdt_osc_clk       <= 1'b0;
      wait_active       <= 1'b0;
      xin_mode_active   <= 1'b0;
    end
    else
    begin
      onchip_periph_clk <= onchip_t;
      hs_osc_full_clk   <= hs_t;
      hs_osc_div_clk    <= hs_div_t;
      ls_osc_clk        <= ls_t;
      div128_clk        <= d128_t;
      wdt_osc_clk       <= wdt_t & wdt_src_protect;
      wait_active       <= in_wait;
      xin_mode_active   <= xin_mode;
    end
  end
endmodule

//--- verilog/sync2.sv
// two flip-flop synchroniser for one level
module sync2 (
  // clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // level in and out
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  // first stage feeds only the second
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule
